/* verilog/monitor_config_defs.svh */
/*
  Register offsets, field positions, reset values and timing counts for the
  monitor configuration bank. Assumes inclusion by bare name.
*/
`ifndef MONITOR_CONFIG_DEFS_SVH
`define MONITOR_CONFIG_DEFS_SVH

// ---------------------------------------------------------------
// Register indices; the byte address is four times the index
// ---------------------------------------------------------------
`define IDX_OFFSET_REMOTE_TWO 8'h72
`define IDX_CONFIG_SECOND 8'h73
`define IDX_CONFIG_FIRST 8'h40
`define IDX_TEST_SECOND 8'h7f
`define IDX_TACH_MIN_HIGH 8'h55
`define IDX_CONFIG_FOURTH 8'h7d
`define IDX_TEMP_RAW 8'h80
`define IDX_TEMP_RESULT 8'h81
`define IDX_STATUS 8'h82
`define ADDR_OF(i) ({2'h0, (i), 2'h0})

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_TWO_WIRE_FIRST 0
`define BIT_TWO_WIRE_SECOND 1
`define BIT_TWO_WIRE_THIRD 2
`define BIT_TWO_WIRE_FOURTH 3
`define BIT_AVG_DISABLE 4
`define BIT_ATTENUATOR_BYPASS_BYPASS 5
`define BIT_SINGLE_CHANNEL 6
`define BIT_SHUTDOWN 7
`define BIT_LOCK 1
`define BIT_EXT_SINGLE_CHANNEL_MODE_CLOCK 2
`define BIT_PWM_INVERT 0

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RESET_OFFSET 8'h00
`define RESET_CONFIG_SECOND 8'h00
`define RESET_BYTE 8'h00
`define RESET_LIMIT 10'h1ff
`define SINGLE_CHANNEL_MODE_TIME_AVG_US 16
`define SINGLE_CHANNEL_MODE_TIME_FAST_US 1
`define CLOCK_MHZ 40
`define SINGLE_CHANNEL_MODE_CYCLES_AVG (`SINGLE_CHANNEL_MODE_TIME_AVG_US * `CLOCK_MHZ)
`define SINGLE_CHANNEL_MODE_CYCLES_FAST (`SINGLE_CHANNEL_MODE_TIME_FAST_US * `CLOCK_MHZ)

`endif

/* verilog/monitor_config_pkg.sv */
/*
  Types shared by the monitor configuration bank.
  Assumes the constants header is compiled alongside.
*/
package monitor_config_pkg;
  typedef enum logic [2:0] {
    CH_SUPPLY_2V5,
    CH_CORE_SUPPLY,
    CH_SUPPLY_3V3,
    CH_SUPPLY_5V,
    CH_SUPPLY_12V,
    CH_REMOTE_ONE,
    CH_LOCAL,
    CH_REMOTE_TWO
  } channel_type;

  typedef enum logic {
    SCAN_ALL,
    SCAN_SINGLE
  } scan_mode_type;
endpackage : monitor_config_pkg

/* verilog/offset_adder.sv */
/*
  Adds a signed quarter-degree offset to a signed temperature result.
  Assumes both values use quarter-degree units, ten bits for the result.
*/
`timescale 1ns/1ps
module offset_adder (
  input wire logic [9:0] raw,
  input wire logic [7:0] offset,
  output logic [9:0] corrected
);
  // ---------------------------------------------------------------
  // Saturating signed sum
  // ---------------------------------------------------------------
  logic signed [10:0] sum;
  always_comb begin
    sum = $signed({raw[9], raw}) + $signed({{3{offset[7]}}, offset});
    if (sum > 11'sd511) begin
      corrected = 10'h1ff;
    end else if (sum < -11'sd512) begin
      corrected = 10'h200;
    end else begin
      corrected = sum[9:0];
    end
  end
endmodule : offset_adder

/* verilog/monitor_config.sv */
/*
  APB register bank for the remote-2 offset and second configuration
  register, with conversion scheduling, tach sense selection and shutdown.
  Assumes an APB master on pclk and a converter that answers single_channel_mode_done.
*/
`timescale 1ns/1ps
`include "monitor_config_defs.svh"
module monitor_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] remote_two_raw,
  input wire logic single_channel_mode_done,
  input wire logic [7:0] duty_current,
  input wire logic ext_single_channel_mode_clock,
  output logic single_channel_mode_start,
  output logic [2:0] single_channel_mode_channel,
  output logic averaging_disable,
  output logic attenuator_bypass,
  output logic [3:0] two_wire_sense,
  output logic [7:0] two_wire_threshold,
  output logic pwm_off,
  output logic pwm_off_level,
  output logic [7:0] duty_readback,
  output logic [9:0] remote_two_result,
  output logic remote_two_over
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] remote_two_temp_offset;
  logic [7:0] monitor_config_second;
  logic [7:0] config_first;
  logic [7:0] test_second;
  logic [7:0] tach_min_high;
  logic [7:0] config_fourth;
  logic [9:0] remote_two_limit;
  logic [9:0] corrected;
  logic [9:0] raw_latched;
  logic wr_en;
  logic rd_en;
  logic locked;
  logic mapped;
  logic [15:0] single_channel_mode_count;
  logic [15:0] single_channel_mode_target;
  logic ext_clk_prev;
  monitor_config_pkg::scan_mode_type scan_mode;
  monitor_config_pkg::channel_type next_channel;
  logic [2:0] scan_channel;

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign locked = config_first[`BIT_LOCK];
  assign scan_mode = monitor_config_second[`BIT_SINGLE_CHANNEL] ?
    monitor_config_pkg::SCAN_SINGLE : monitor_config_pkg::SCAN_ALL;

  always_comb begin
    mapped = 1'b1;
    case (paddr[9:2])
      `IDX_OFFSET_REMOTE_TWO, `IDX_CONFIG_SECOND, `IDX_CONFIG_FIRST,
      `IDX_TEST_SECOND, `IDX_TACH_MIN_HIGH, `IDX_CONFIG_FOURTH,
      `IDX_TEMP_RAW, `IDX_TEMP_RESULT, `IDX_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // APB handshake: one wait-free access phase
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Lock is sticky once set; only reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_first <= `RESET_BYTE;
    end else if (wr_en && mapped && paddr[9:2] == `IDX_CONFIG_FIRST && !locked) begin
      config_first <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_two_temp_offset <= `RESET_OFFSET;
      monitor_config_second <= `RESET_CONFIG_SECOND;
      test_second <= `RESET_BYTE;
      tach_min_high <= `RESET_BYTE;
      config_fourth <= `RESET_BYTE;
    end else if (wr_en && mapped && !locked) begin
      case (paddr[9:2])
        `IDX_OFFSET_REMOTE_TWO: remote_two_temp_offset <= pwdata[7:0];
        `IDX_CONFIG_SECOND: monitor_config_second <= pwdata[7:0];
        `IDX_TEST_SECOND: test_second <= pwdata[7:0];
        `IDX_TACH_MIN_HIGH: tach_min_high <= pwdata[7:0];
        `IDX_CONFIG_FOURTH: config_fourth <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Limit lives with the status word; not locked, so software can move it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_two_limit <= `RESET_LIMIT;
    end else if (wr_en && paddr[9:2] == `IDX_STATUS && paddr[11:10] == 2'h0) begin
      remote_two_limit <= pwdata[9:0];
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      case (paddr[9:2])
        `IDX_OFFSET_REMOTE_TWO: prdata <= {24'h0, remote_two_temp_offset};
        `IDX_CONFIG_SECOND: prdata <= {24'h0, monitor_config_second};
        `IDX_CONFIG_FIRST: prdata <= {24'h0, config_first};
        `IDX_TEST_SECOND: prdata <= {24'h0, test_second};
        `IDX_TACH_MIN_HIGH: prdata <= {24'h0, tach_min_high};
        `IDX_CONFIG_FOURTH: prdata <= {24'h0, config_fourth};
        `IDX_TEMP_RAW: prdata <= {22'h0, raw_latched};
        `IDX_TEMP_RESULT: prdata <= {22'h0, remote_two_result};
        `IDX_STATUS: prdata <= {21'h0, remote_two_over, remote_two_limit};
        default: prdata <= 32'h0;
      endcase
      if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
        prdata <= 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Offset correction ahead of store and compare
  // ---------------------------------------------------------------
  offset_adder u_offset_adder (
    .raw(raw_latched),
    .offset(remote_two_temp_offset),
    .corrected(corrected)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_latched <= 10'h0;
    end else if (single_channel_mode_done && single_channel_mode_channel == 3'(monitor_config_pkg::CH_REMOTE_TWO)) begin
      raw_latched <= remote_two_raw;
    end
  end

  // Stored and compared one cycle after capture, so both see the sum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_two_result <= 10'h0;
      remote_two_over <= 1'b0;
    end else begin
      remote_two_result <= corrected;
      remote_two_over <= $signed(corrected) > $signed(remote_two_limit);
    end
  end

  // ---------------------------------------------------------------
  // Conversion scheduling
  // ---------------------------------------------------------------
  assign single_channel_mode_target = monitor_config_second[`BIT_AVG_DISABLE] ?
    16'(`SINGLE_CHANNEL_MODE_CYCLES_FAST) : 16'(`SINGLE_CHANNEL_MODE_CYCLES_AVG);

  always_comb begin
    if (scan_mode == monitor_config_pkg::SCAN_SINGLE) begin
      next_channel = monitor_config_pkg::channel_type'(tach_min_high[7:5]);
    end else begin
      next_channel = monitor_config_pkg::channel_type'(scan_channel + 3'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clk_prev <= 1'b0;
    end else begin
      ext_clk_prev <= ext_single_channel_mode_clock;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_channel_mode_count <= 16'h0;
      single_channel_mode_start <= 1'b0;
      scan_channel <= 3'h0;
      single_channel_mode_channel <= 3'h0;
    end else begin
      single_channel_mode_start <= 1'b0;
      if (monitor_config_second[`BIT_SHUTDOWN]) begin
        single_channel_mode_count <= 16'h0;
      end else if (scan_mode == monitor_config_pkg::SCAN_SINGLE &&
                   test_second[`BIT_EXT_SINGLE_CHANNEL_MODE_CLOCK]) begin
        if (ext_single_channel_mode_clock && !ext_clk_prev) begin
          single_channel_mode_start <= 1'b1;
          single_channel_mode_channel <= tach_min_high[7:5];
        end
      end else if (single_channel_mode_count >= single_channel_mode_target - 16'h1) begin
        single_channel_mode_count <= 16'h0;
        single_channel_mode_start <= 1'b1;
        scan_channel <= 3'(next_channel);
        single_channel_mode_channel <= 3'(next_channel);
      end else begin
        single_channel_mode_count <= single_channel_mode_count + 16'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Static configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_wire_sense <= 4'h0;
      two_wire_threshold <= 8'h0;
      averaging_disable <= 1'b0;
      attenuator_bypass <= 1'b0;
    end else begin
      two_wire_sense[1:0] <= monitor_config_second[1:0];
      two_wire_sense[2] <= monitor_config_second[`BIT_TWO_WIRE_THIRD];
      two_wire_sense[3] <= monitor_config_second[`BIT_TWO_WIRE_FOURTH];
      two_wire_threshold <= config_fourth;
      averaging_disable <= monitor_config_second[`BIT_AVG_DISABLE];
      attenuator_bypass <= monitor_config_second[`BIT_ATTENUATOR_BYPASS_BYPASS];
    end
  end

  // Fan-off level follows polarity; duty reads zero while shut down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_off <= 1'b0;
      pwm_off_level <= 1'b0;
      duty_readback <= 8'h0;
    end else begin
      pwm_off <= monitor_config_second[`BIT_SHUTDOWN];
      pwm_off_level <= config_first[`BIT_PWM_INVERT];
      duty_readback <= monitor_config_second[`BIT_SHUTDOWN] ? 8'h0 : duty_current;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_locked_write;
    locked && psel && penable && pwrite && pready;
  endsequence

  a_lock_blocks_cfg: assert property (
    s_locked_write |=> $stable(monitor_config_second) && $stable(remote_two_temp_offset))
    else $error("locked write changed a register");
  a_result_offset: assert property (
    $stable(raw_latched) && $stable(remote_two_temp_offset) |->
    (remote_two_result == corrected))
    else $error("result lacks offset");
  a_offset_sign: assert property (
    remote_two_temp_offset[7] && $signed(raw_latched) > -10'sd300 |->
    $signed(corrected) < $signed(raw_latched))
    else $error("negative offset did not reduce");
  a_shutdown_duty: assert property (
    monitor_config_second[`BIT_SHUTDOWN] |=> duty_readback == 8'h0 && pwm_off)
    else $error("shutdown duty not zero");
  a_sense_follow: assert property (
    ##1 two_wire_sense == $past(monitor_config_second[3:0]))
    else $error("sense select lag");
  a_threshold_follow: assert property (
    ##1 two_wire_threshold == $past(config_fourth))
    else $error("threshold mismatch");
  a_avg_bit: assert property (
    ##1 averaging_disable == $past(monitor_config_second[4]) &&
    attenuator_bypass == $past(monitor_config_second[5]))
    else $error("avg or attenuator_bypass output mismatch");
  a_single_channel: assert property (
    single_channel_mode_start && $past(scan_mode == monitor_config_pkg::SCAN_SINGLE) &&
    $past(scan_mode == monitor_config_pkg::SCAN_SINGLE, 2) &&
    $stable(tach_min_high) |-> single_channel_mode_channel == tach_min_high[7:5])
    else $error("wrong single channel");
  a_ext_start: assert property (
    scan_mode == monitor_config_pkg::SCAN_SINGLE && test_second[2] &&
    !monitor_config_second[7] && ext_single_channel_mode_clock && !ext_clk_prev |=> single_channel_mode_start)
    else $error("external clock missed");
  a_over_cmp: assert property (
    ##1 remote_two_over == ($signed(remote_two_result) > $signed($past(remote_two_limit))))
    else $error("compare used uncorrected value");
  a_reset_zero: assert property (
    $rose(presetn) |-> monitor_config_second == 8'h00)
    else $error("config not zero after reset");
endmodule : monitor_config

/* tb/monitor_config_tb.sv */
/*
  Self-checking bench for the monitor configuration bank.
  Assumes the design files and the constants header are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module monitor_config_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic single_channel_mode_done = 0, ext_single_channel_mode_clock = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [9:0] remote_two_raw = 10'h000, remote_two_result, lim, res;
  logic [7:0] duty_current = 8'h00, v, off, two_wire_threshold, duty_readback;
  logic pready, pslverr, single_channel_mode_start, averaging_disable, attenuator_bypass;
  logic pwm_off, pwm_off_level, remote_two_over;
  logic [2:0] single_channel_mode_channel;
  logic [3:0] two_wire_sense;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  monitor_config i_monitor_config (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .remote_two_raw(remote_two_raw),
    .single_channel_mode_done(single_channel_mode_done), .duty_current(duty_current), .ext_single_channel_mode_clock(ext_single_channel_mode_clock),
    .single_channel_mode_start(single_channel_mode_start), .single_channel_mode_channel(single_channel_mode_channel),
    .averaging_disable(averaging_disable), .attenuator_bypass(attenuator_bypass),
    .two_wire_sense(two_wire_sense), .two_wire_threshold(two_wire_threshold),
    .pwm_off(pwm_off), .pwm_off_level(pwm_off_level), .duty_readback(duty_readback),
    .remote_two_result(remote_two_result), .remote_two_over(remote_two_over));
  // ---------------------------------------------------------------
  // Clock, monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      `CHK("prdata", exp_q[0][31:0], prdata)
      `CHK("pslverr", exp_q[0][32], pslverr)
      void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    if (!w) exp_q.push_back({e, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 1'b0);
  endtask : rd
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  // Counts edges up to the next start pulse; the watchdog bounds it
  task automatic wait_start();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (single_channel_mode_start !== 1'b1);
  endtask : wait_start
  function automatic logic [9:0] sat(input logic [9:0] r, input logic [7:0] o);
    logic signed [11:0] s;
    s = $signed({{2{r[9]}}, r}) + $signed({{4{o[7]}}, o});
    if (s > 511) return 10'h1ff;
    if (s < -512) return 10'h200;
    return s[9:0];
  endfunction : sat
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(52));
    cyc(10);
    presetn <= 1'b1;
    rd(12'h1c8, 32'h0);
    rd(12'h1cc, 32'h0);
    `CHK("pwm_off", 1'b0, pwm_off)
    apb(1'b0, 12'h3f0, 32'h0, 1'b1);
    v = 8'($urandom);
    wr(12'h1f4, v);
    cyc(3);
    `CHK("two_wire_threshold", v, two_wire_threshold)
    duty_current <= 8'($urandom);
    wr(12'h100, 8'h01);
    for (int b = 0; b < 8; b++) begin
      v = 8'h01 << b;
      wr(12'h1cc, v);
      cyc(3);
      `CHK("two_wire_sense", v[3:0], two_wire_sense)
      `CHK("averaging_disable", v[4], averaging_disable)
      `CHK("attenuator_bypass", v[5], attenuator_bypass)
      `CHK("pwm_off", v[7], pwm_off)
      `CHK("pwm_off_level", 1'b1, pwm_off_level)
      `CHK("duty_readback", v[7] ? 8'h00 : duty_current, duty_readback)
      rd(12'h1cc, {24'h0, v});
    end
    wr(12'h100, 8'h00);
    wr(12'h1cc, 8'h00);
    wait_start();
    v = {5'h0, single_channel_mode_channel};
    wait_start();
    `CHK("scan channel", 3'(v + 8'h1), single_channel_mode_channel)
    `CHK("start period", 640, n)
    `CHK("pwm_off_level", 1'b0, pwm_off_level)
    wr(12'h1cc, 8'h50);
    for (int c = 0; c < 8; c++) begin
      wr(12'h154, 8'(c << 5));
      wait_start();
      wait_start();
      `CHK("single_channel_mode_channel", 3'(c), single_channel_mode_channel)
      wait_start();
      `CHK("single_channel_mode_channel", 3'(c), single_channel_mode_channel)
      `CHK("start period", 40, n)
    end
    for (int k = 0; k < 6; k++) begin
      off = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : 8'($urandom);
      remote_two_raw <= (k == 0) ? 10'h205 : (k == 1) ? 10'h1f0 : 10'($urandom);
      lim = 10'($urandom);
      wr(12'h1c8, off);
      wr(12'h208, lim[7:0]);
      apb(1'b1, 12'h208, {22'h0, lim}, 1'b0);
      rd(12'h1c8, {24'h0, off});
      wait_start();
      single_channel_mode_done <= 1'b1;
      @(posedge pclk);
      single_channel_mode_done <= 1'b0;
      cyc(4);
      res = sat(remote_two_raw, off);
      `CHK("remote_two_result", res, remote_two_result)
      `CHK("remote_two_over", $signed(res) > $signed(lim), remote_two_over)
      rd(12'h204, {22'h0, res});
    end
    wr(12'h1fc, 8'h04);
    cyc(2);
    ext_single_channel_mode_clock <= 1'b1;
    n = 0;
    for (int t = 0; t < 4; t++) begin
      @(posedge pclk);
      if (single_channel_mode_start === 1'b1) n++;
    end
    `CHK("external start", 1, n)
    ext_single_channel_mode_clock <= 1'b0;
    // Lock last: only reset can undo it
    wr(12'h100, 8'h03);
    wr(12'h1cc, 8'h0f);
    wr(12'h1c8, 8'h11);
    cyc(3);
    rd(12'h1cc, 32'h50);
    rd(12'h1c8, {24'h0, off});
    `CHK("two_wire_sense", 4'h0, two_wire_sense)
    report_and_stop();
  end
endmodule : monitor_config_tb
